/* rcds_map.svh */
// Constants for the deep-sleep sequencer: field widths, reset values, timing
`ifndef RCDS_MAP_SVH
`define RCDS_MAP_SVH
`define RCDS_DUR_W         32
`define RCDS_LEAD_W        10
`define RCDS_SLOT_US       625
`define RCDS_LP_HZ_DEF     32768
`define RCDS_CLK_HZ        50000000
`define RCDS_LP_DIV        (`RCDS_CLK_HZ / `RCDS_LP_HZ_DEF)
`define RCDS_ASSERT_RST    10'h020
`define RCDS_DEASSERT_RST  10'h001
`define RCDS_EXTW_RST      10'h002
`endif

/* rcds_pkg.sv */
// Types shared by the deep-sleep sequencer
package rcds_pkg;
   typedef enum logic [4:0] {
      RCDS_ACTIVE  = 5'h01,
      RCDS_ENTER   = 5'h02,
      RCDS_SLEEP   = 5'h04,
      RCDS_EXPIRED = 5'h08,
      RCDS_EXIT    = 5'h10
   } rcds_state_e;
endpackage

/* rcds_lp_tick.sv */
// Low-power clock tick divider
`timescale 1ns/100ps
module rcds_lp_tick #(
   parameter int DIV = 1526
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic run,
   output logic      tick
);
   logic [15:0] cnt_r;

   // One-cycle enable every DIV system clocks while running
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 16'h0000;
         tick  <= 1'b0;
      end else if (!run) begin
         cnt_r <= 16'h0000;
         tick  <= 1'b0;
      end else if (cnt_r == 16'(DIV - 1)) begin
         cnt_r <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule

/* rcds_sequencer.sv */
// Deep-sleep entry and exit sequencer for the radio baseband core
// How it works
// - Sleep runs on low-power clock ticks
// - Exit only on expiry or wake request
// - Early warning rises set-lead ticks before expiry
// - After expiry, sleep holds until warned, core powered, request width spent
// - Exit needs expiry, clocks on, radio up
// - Wake request raises warning at once, width-timed
// - Pending wake request blocks sleep entry
// - External wake disable ignores wake request in sleep, not at entry
// - Warning always precedes sleep-exit interrupt
// - Assert lead sets warning rise point
// - Deassert lead sets warning fall point
`timescale 1ns/100ps
`include "rcds_map.svh"
module rcds_sequencer #(
   parameter int DUR_W  = `RCDS_DUR_W,
   parameter int LEAD_W = `RCDS_LEAD_W,
   parameter int LP_DIV = `RCDS_LP_DIV
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              deep_sleep_on,
   input  wire logic              external_wake_disable,
   input  wire logic              software_wake_request,
   input  wire logic [DUR_W-1:0]  sleep_duration_cycles,
   input  wire logic [LEAD_W-1:0] wake_irq_assert_lead,
   input  wire logic [LEAD_W-1:0] wake_irq_deassert_lead,
   input  wire logic [LEAD_W-1:0] external_wake_irq_width,
   input  wire logic              core_clock_enable,
   input  wire logic              radio_powered_flag,
   output logic                   power_down_allowed_flag,
   output logic                   low_power_timing,
   output logic                   wake_early_warning_irq,
   output logic                   sleep_exit_irq,
   output logic [DUR_W-1:0]       actual_sleep_duration,
   output logic                   deep_sleep_active
);
   rcds_pkg::rcds_state_e state_r;
   rcds_pkg::rcds_state_e state_nxt;
   logic [DUR_W-1:0]  elapsed_r;
   logic [DUR_W-1:0]  remain_r;
   logic [LEAD_W-1:0] ext_cnt_r;
   logic              ext_run_r;
   logic              warned_r;
   logic              lp_tick;
   logic              lp_run;
   logic              wake_req_ok;
   logic              core_up;
   logic              asleep;

   // Remaining ticks compared against a lead value, zero-extended
   function automatic logic at_lead(input logic [DUR_W-1:0] rem,
                                    input logic [LEAD_W-1:0] lead);
      at_lead = (rem == DUR_W'(lead));
   endfunction

   // Request width spent once this tick would bring the count to the deassert lead,
   // so width = lead + X holds the warning X slow periods; one bit wider so no wrap
   function automatic logic width_done(input logic [LEAD_W-1:0] cnt,
                                       input logic [LEAD_W-1:0] lead);
      width_done = (cnt == '0) ||
                   ({1'b0, cnt} <= ({1'b0, lead} + (LEAD_W+1)'(1)));
   endfunction

   assign wake_req_ok = software_wake_request && !external_wake_disable;
   assign core_up     = core_clock_enable && radio_powered_flag;
   assign asleep      = (state_r == rcds_pkg::RCDS_SLEEP) ||
                        (state_r == rcds_pkg::RCDS_EXPIRED);
   // Divider only runs while the slot reference lives on the slow clock
   assign lp_run      = asleep || ext_run_r;

   rcds_lp_tick #(
      .DIV (LP_DIV)
   ) u_tick (
      .clk  (clk),
      .rst  (rst),
      .run  (lp_run),
      .tick (lp_tick)
   );

   // Next state of the sequence
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         rcds_pkg::RCDS_ACTIVE: begin
            // A pending wake request forbids entry
            if (deep_sleep_on && !software_wake_request)
               state_nxt = rcds_pkg::RCDS_ENTER;
         end
         rcds_pkg::RCDS_ENTER: begin
            state_nxt = rcds_pkg::RCDS_SLEEP;
         end
         rcds_pkg::RCDS_SLEEP: begin
            // Only expiry or an accepted request ends sleep
            if (wake_req_ok)
               state_nxt = rcds_pkg::RCDS_EXPIRED;
            else if (lp_tick && remain_r <= DUR_W'(1))
               state_nxt = rcds_pkg::RCDS_EXPIRED;
         end
         rcds_pkg::RCDS_EXPIRED: begin
            // Hold until warned, the core is clocked and powered, and any request width is spent
            if (core_up && warned_r && !ext_run_r)
               state_nxt = rcds_pkg::RCDS_EXIT;
         end
         rcds_pkg::RCDS_EXIT: begin
            state_nxt = rcds_pkg::RCDS_ACTIVE;
         end
         default: state_nxt = rcds_pkg::RCDS_ACTIVE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         state_r <= rcds_pkg::RCDS_ACTIVE;
      else
         state_r <= state_nxt;
   end

   // Sleep countdown and elapsed count in low-power ticks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         remain_r  <= '0;
         elapsed_r <= '0;
      end else if (state_r == rcds_pkg::RCDS_ENTER) begin
         remain_r  <= sleep_duration_cycles;
         elapsed_r <= '0;
      end else if (asleep && lp_tick) begin
         if (remain_r != '0)
            remain_r <= remain_r - DUR_W'(1);
         elapsed_r <= elapsed_r + DUR_W'(1);
      end
   end

   // Actual duration captured on exit; exceeds programmed if held
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         actual_sleep_duration <= '0;
      else if (state_r == rcds_pkg::RCDS_EXIT)
         actual_sleep_duration <= elapsed_r;
   end

   // Request-driven warning width counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_run_r <= 1'b0;
         ext_cnt_r <= '0;
      end else if (state_r == rcds_pkg::RCDS_SLEEP && wake_req_ok) begin
         ext_run_r <= 1'b1;
         ext_cnt_r <= external_wake_irq_width;
      end else if (ext_run_r && lp_tick) begin
         // Falls on the tick that would bring the count to the deassert lead
         if (width_done(ext_cnt_r, wake_irq_deassert_lead))
            ext_run_r <= 1'b0;
         else
            ext_cnt_r <= ext_cnt_r - LEAD_W'(1);
      end
   end

   // Early warning level: rise at assert lead, fall at deassert lead
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_early_warning_irq <= 1'b0;
         warned_r               <= 1'b0;
      end else if (state_r == rcds_pkg::RCDS_ENTER) begin
         wake_early_warning_irq <= 1'b0;
         warned_r               <= 1'b0;
      end else if (state_r == rcds_pkg::RCDS_SLEEP && wake_req_ok) begin
         wake_early_warning_irq <= 1'b1;
         warned_r               <= 1'b1;
      end else if (ext_run_r) begin
         if (lp_tick && width_done(ext_cnt_r, wake_irq_deassert_lead))
            wake_early_warning_irq <= 1'b0;
      end else if (asleep && lp_tick) begin
         if (state_r == rcds_pkg::RCDS_SLEEP &&
             (at_lead(remain_r, wake_irq_assert_lead) ||
              (!warned_r && remain_r <= DUR_W'(wake_irq_assert_lead)))) begin
            wake_early_warning_irq <= 1'b1;
            warned_r               <= 1'b1;
         end else if (warned_r && remain_r <= DUR_W'(wake_irq_deassert_lead)) begin
            wake_early_warning_irq <= 1'b0;
         end
      end else if (state_r == rcds_pkg::RCDS_EXIT) begin
         // Warning always seen before exit interrupt
         wake_early_warning_irq <= 1'b0;
      end
   end

   // Sleep-exit interrupt pulse, only after the warning
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         sleep_exit_irq <= 1'b0;
      else
         sleep_exit_irq <= (state_r == rcds_pkg::RCDS_EXIT);
   end

   // Power-down permission and timing source flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_down_allowed_flag <= 1'b0;
         low_power_timing        <= 1'b0;
         deep_sleep_active       <= 1'b0;
      end else begin
         power_down_allowed_flag <= (state_nxt == rcds_pkg::RCDS_SLEEP) ||
                                    (state_nxt == rcds_pkg::RCDS_EXPIRED);
         low_power_timing        <= (state_nxt == rcds_pkg::RCDS_SLEEP) ||
                                    (state_nxt == rcds_pkg::RCDS_EXPIRED);
         deep_sleep_active       <= (state_nxt != rcds_pkg::RCDS_ACTIVE);
      end
   end
endmodule

/* rcds_sequencer_assertions.sv */
// Port checks for the deep-sleep sequencer
`timescale 1ns/100ps
module rcds_sequencer_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic deep_sleep_on,
   input wire logic external_wake_disable,
   input wire logic software_wake_request,
   input wire logic core_clock_enable,
   input wire logic radio_powered_flag,
   input wire logic power_down_allowed_flag,
   input wire logic low_power_timing,
   input wire logic wake_early_warning_irq,
   input wire logic sleep_exit_irq,
   input wire logic deep_sleep_active
);
   logic warned_r;
   // Warning seen since the last exit
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         warned_r <= 1'b0;
      else
         warned_r <= !sleep_exit_irq && (warned_r || wake_early_warning_irq);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_entry;
      !deep_sleep_active && deep_sleep_on && !software_wake_request;
   endsequence
   sequence s_exit_pulse;
      sleep_exit_irq ##1 !sleep_exit_irq;
   endsequence
   a_entry_flag_rise: assert property (s_entry |-> ##2 power_down_allowed_flag)
      else $error("entry not flagged");
   a_lp_timing_follow: assert property (low_power_timing == power_down_allowed_flag)
      else $error("slow timing mismatch");
   a_entry_refused: assert property (
      !deep_sleep_active && software_wake_request |=> !deep_sleep_active)
      else $error("entry during wake request");
   a_exit_needs_power: assert property (
      sleep_exit_irq |-> core_clock_enable && radio_powered_flag)
      else $error("exit while unpowered");
   a_exit_one_pulse: assert property (sleep_exit_irq |-> s_exit_pulse)
      else $error("exit pulse too long");
   a_flags_clear: assert property (
      sleep_exit_irq |-> !power_down_allowed_flag && !deep_sleep_active)
      else $error("flags left set");
   a_warn_first: assert property (sleep_exit_irq |-> warned_r)
      else $error("exit without warning");
   a_request_warns: assert property ($rose(software_wake_request) && power_down_allowed_flag
      && !external_wake_disable |-> ##1 wake_early_warning_irq)
      else $error("request gave no warning");
   a_disable_ignores: assert property ($rose(software_wake_request) && external_wake_disable
      && power_down_allowed_flag && !wake_early_warning_irq |=> !wake_early_warning_irq)
      else $error("disabled request woke");
   a_hold_asleep: assert property (
      deep_sleep_active && !radio_powered_flag |=> deep_sleep_active)
      else $error("left sleep unpowered");
endmodule
bind rcds_sequencer rcds_sequencer_assertions u_rcds_sequencer_assertions (.clk, .rst,
   .deep_sleep_on, .external_wake_disable, .software_wake_request, .core_clock_enable,
   .radio_powered_flag, .power_down_allowed_flag, .low_power_timing, .wake_early_warning_irq,
   .sleep_exit_irq, .deep_sleep_active);

/* rcds_sw_model.sv */
// Software and power control model around the sequencer
`timescale 1ns/100ps
module rcds_sw_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        power_down_allowed_flag,
   input  wire logic        wake_early_warning_irq,
   input  wire logic [15:0] wake_delay,
   output logic             core_clock_enable,
   output logic             radio_powered_flag
);
   logic        seen_r;
   logic [15:0] cnt_r;
   // Gate on entry; power back up a settable time after the warning
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_clock_enable <= 1'b1;
         radio_powered_flag <= 1'b1;
         seen_r <= 1'b0;
         cnt_r <= 16'h0000;
      end else begin
         seen_r <= power_down_allowed_flag;
         if (power_down_allowed_flag && !seen_r) begin
            core_clock_enable <= 1'b0;
            radio_powered_flag <= 1'b0;
            cnt_r <= 16'h0000;
         end else if (!core_clock_enable && (wake_early_warning_irq || cnt_r != 16'h0000)) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == wake_delay) begin
               core_clock_enable <= 1'b1;
               radio_powered_flag <= 1'b1;
            end
         end
      end
   end
endmodule

/* tb_rcds_sequencer.sv */
// Testbench for the deep-sleep sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, a, b); end end
module tb_rcds_sequencer;
   logic        clk, rst, dso, ewd, swr, cce, rpf, pda, lpt, wew, sei, dsa, ok;
   logic [31:0] dur, act;
   logic [9:0]  al, dl, ew;
   logic [15:0] wd;
   int          mismatches, n_compared, i;
   int          cyc = 0;
   int          wn;
   localparam int LPD = 4;  // Slow tick period in system clocks, kept short for the run
   rcds_sequencer #(.LP_DIV(LPD)) u_rcds_sequencer (.clk, .rst, .deep_sleep_on(dso),
      .external_wake_disable(ewd), .software_wake_request(swr), .sleep_duration_cycles(dur),
      .wake_irq_assert_lead(al), .wake_irq_deassert_lead(dl), .external_wake_irq_width(ew),
      .core_clock_enable(cce), .radio_powered_flag(rpf), .power_down_allowed_flag(pda),
      .low_power_timing(lpt), .wake_early_warning_irq(wew), .sleep_exit_irq(sei),
      .actual_sleep_duration(act), .deep_sleep_active(dsa));
   rcds_sw_model u_rcds_sw_model (.clk, .rst, .power_down_allowed_flag(pda),
      .wake_early_warning_irq(wew), .wake_delay(wd), .core_clock_enable(cce),
      .radio_powered_flag(rpf));
   // Clock at 50 MHz
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Warning cycles per sleep; cleared while sleep-on is requested
   always @(posedge clk) begin
      if (dso === 1'b1)
         wn <= 0;
      else if (wew === 1'b1)
         wn <= wn + 1;
   end
   // Program leads, then duration, then sleep-on; wait for entry
   task automatic enter(input logic [31:0] d);
      al = 10'h004;
      dl = 10'h001;
      ew = dl + 10'h001;
      dur = d;
      dso = 1'b1;
      for (i = 0; i < 50 && pda !== 1'b1; i++) @(negedge clk);
      dso = 1'b0;
      `CHK(pda, 1'b1)
      `CHK(lpt, 1'b1)
   endtask
   // Pulse lasts a whole cycle, so falling-edge sampling cannot miss it
   task automatic wait_exit(input int n, input int wlo, input int whi);
      ok = 1'b0;
      for (i = 0; i < n && !ok; i++) begin
         @(negedge clk);
         ok = (sei === 1'b1);
      end
      `CHK(ok, 1'b1)
      `CHK(pda, 1'b0)
      `CHK(wn >= wlo && wn <= whi, 1'b1)
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   // Timer exit, late power-up, disabled and honoured wake request
   initial begin
      {rst, dso, ewd, swr, dur, al, dl, ew} = {1'b1, 3'h0, 32'h0, 30'h0};
      wd = 16'h0002;
      mismatches = 0;
      n_compared = 0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      `CHK({pda, wew, sei, dsa}, 4'h0)
      $display("test reset done");
      enter(32'h0000000c);
      wait_exit(400, int'(al - dl) * LPD, int'(al - dl) * LPD);
      `CHK(act >= 32'h0000000c, 1'b1)
      $display("test timer exit done");
      wd = 16'h00c8;
      enter(32'h0000000c);
      wait_exit(900, int'(al - dl) * LPD, int'(al - dl) * LPD);
      `CHK(act > 32'h0000000c, 1'b1)
      $display("test late power-up done");
      wd = 16'h0002;
      enter(32'h000003e8);
      ewd = 1'b1;
      swr = 1'b1;
      repeat (40) @(negedge clk);
      `CHK(wew, 1'b0)
      ewd = 1'b0;
      swr = 1'b0;
      @(negedge clk);
      swr = 1'b1;
      wait_exit(400, 1, LPD);
      `CHK(act < 32'h000003e8, 1'b1)
      dso = 1'b1;
      repeat (5) @(negedge clk);
      `CHK(dsa, 1'b0)
      dso = 1'b0;
      swr = 1'b0;
      $display("test wake request done");
      finish_test();
   end
endmodule
